// ### bench/alu_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module alu_asserts #(
  parameter int DATA_W = 8
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              clk_en,
  input wire logic              op_valid,
  input wire logic [3:0]        op_code,
  input wire logic [DATA_W-1:0] mem_rd_data,
  input wire logic [DATA_W-1:0] acc,
  input wire logic              zero_flag,
  input wire logic              carry_flag,
  input wire logic [DATA_W-1:0] mem_wr_data,
  input wire logic              mem_wr_en,
  input wire logic              op_done
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic              tk;
  logic [DATA_W-1:0] pm;
  logic [DATA_W-1:0] pa;
  logic              pc;
  assign tk = clk_en && op_valid;
  // Operands of the previous edge, so each check names what it reads.
  always_ff @(posedge core_clk) begin
    pm <= mem_rd_data;
    pa <= acc;
    pc <= carry_flag;
  end
  chk_dec_acc: assert property (tk && op_code == 4'h1 |=> acc == pm - 8'h01 && zero_flag == (acc == 8'h00))
    else $error("dec to acc wrong");
  chk_inc_mem: assert property (tk && op_code == 4'h2 |=> mem_wr_en && mem_wr_data == pm + 8'h01 && $stable(acc))
    else $error("inc in place wrong");
  chk_inc_acc: assert property (tk && op_code == 4'h3 |=> acc == pm + 8'h01 && !mem_wr_en && $stable(carry_flag))
    else $error("inc to acc wrong");
  chk_copy_acc: assert property (tk && op_code == 4'h4 |=> acc == pm && $stable(zero_flag))
    else $error("copy to acc wrong");
  chk_copy_mem: assert property (tk && op_code == 4'h5 |=> mem_wr_en && mem_wr_data == pa)
    else $error("copy to mem wrong");
  chk_or_acc: assert property (tk && op_code == 4'h6 |=> acc == (pa | pm) && zero_flag == (acc == 8'h00))
    else $error("or to acc wrong");
  chk_rl_mem: assert property (tk && op_code == 4'h8 |=> mem_wr_data == ((pm << 1) | (pm >> 7)))
    else $error("rotate left wrong");
  chk_rlc_acc: assert property (tk && op_code == 4'hB |=> acc == ((pm << 1) | pc) && carry_flag == pm[7])
    else $error("rotate carry wrong");
  chk_rr_mem: assert property (tk && op_code == 4'hC |=> mem_wr_data == ((pm >> 1) | (pm << 7)))
    else $error("rotate right wrong");
  chk_or_mem: assert property (tk && op_code == 4'h7 |=> mem_wr_en && mem_wr_data == (pa | pm) && zero_flag == (mem_wr_data == 8'h00))
    else $error("or to mem wrong");
  chk_rl_acc: assert property (tk && op_code == 4'h9 |=> acc == ((pm << 1) | (pm >> 7)) && !mem_wr_en && $stable(carry_flag))
    else $error("rotate left to acc wrong");
  chk_rlc_mem: assert property (tk && op_code == 4'hA |=> mem_wr_en && mem_wr_data == ((pm << 1) | pc) && carry_flag == pm[7])
    else $error("rotate carry in place wrong");
  chk_flags_hold: assert property (tk && (op_code == 4'h5 || op_code == 4'h8 || op_code == 4'hC) |=> $stable(zero_flag) && $stable(carry_flag))
    else $error("flags moved on a flagless op");
endmodule : alu_asserts
bind mem_inc_dec_move_or_rotate_alu alu_asserts #(.DATA_W(DATA_W)) u_chk (.core_clk, .rst, .clk_en, .op_valid,
  .op_code, .mem_rd_data, .acc, .zero_flag, .carry_flag, .mem_wr_data, .mem_wr_en, .op_done);
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       core_clk, rst, clk_en, op_valid;
  logic [3:0] op_code;
  logic [7:0] mem_rd_data, acc, mem_wr_data;
  logic       zero_flag, carry_flag, mem_wr_en, op_done;
  int         err_count, num_checks;
  mem_inc_dec_move_or_rotate_alu u_dut (.core_clk, .rst, .clk_en, .op_valid, .op_code, .mem_rd_data,
    .acc, .zero_flag, .carry_flag, .mem_wr_data, .mem_wr_en, .op_done);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic op(input logic [3:0] c, input logic [7:0] m);
    @(posedge core_clk);
    #1;
    op_valid = 1'b1;
    op_code = c;
    mem_rd_data = m;
    @(posedge core_clk);
    #1;
    op_valid = 1'b0;
  endtask : op
  // Rotates run first so that carry ends high for the increment checks.
  task automatic t_rot;
    op(4'h8, 8'h81);
    cmp("rl mem", 8'h03, mem_wr_data);
    op(4'h9, 8'h80);
    cmp("rl acc", 8'h01, acc);
    cmp("rl wr", 8'h00, mem_wr_en);
    op(4'hB, 8'hC0);
    cmp("rlc acc", 8'h80, acc);
    cmp("rlc acc c", 8'h01, carry_flag);
    op(4'hA, 8'h80);
    cmp("rlc mem", 8'h01, mem_wr_data);
    cmp("rlc c", 8'h01, carry_flag);
    op(4'hC, 8'h01);
    cmp("rr mem", 8'h80, mem_wr_data);
    cmp("rr z", 8'h00, zero_flag);
  endtask : t_rot
  task automatic t_incdec;
    op(4'h1, 8'h01);
    cmp("dec zero", 8'h01, zero_flag);
    op(4'h1, 8'h00);
    cmp("dec acc", 8'hFF, acc);
    cmp("dec wr", 8'h00, mem_wr_en);
    cmp("dec z", 8'h00, zero_flag);
    op(4'h3, 8'h7F);
    cmp("inc acc", 8'h80, acc);
    op(4'h2, 8'hFF);
    cmp("inc mem", 8'h00, mem_wr_data);
    cmp("inc wr", 8'h01, mem_wr_en);
    cmp("inc z", 8'h01, zero_flag);
    cmp("inc c", 8'h01, carry_flag);
  endtask : t_incdec
  task automatic t_move_or;
    op(4'h4, 8'h3C);
    cmp("mov acc", 8'h3C, acc);
    cmp("mov z", 8'h01, zero_flag);
    op(4'h5, 8'h77);
    cmp("mov mem", 8'h3C, mem_wr_data);
    op(4'h6, 8'h5A);
    cmp("or acc", 8'h7E, acc);
    cmp("or acc z", 8'h00, zero_flag);
    op(4'h7, 8'hA5);
    cmp("or mem", 8'hFF, mem_wr_data);
    cmp("or z", 8'h00, zero_flag);
    op(4'h4, 8'h00);
    cmp("mov z held", 8'h00, zero_flag);
    op(4'h7, 8'h00);
    cmp("or mem zero", 8'h00, mem_wr_data);
    cmp("or mem z", 8'h01, zero_flag);
  endtask : t_move_or
  task automatic t_reset;
    op(4'h4, 8'h5A);
    cmp("pre acc", 8'h5A, acc);
    @(posedge core_clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    cmp("reset acc again", 8'h00, acc);
    cmp("reset z", 8'h00, zero_flag);
    cmp("reset c", 8'h00, carry_flag);
    op(4'h6, 8'h00);
    cmp("or acc z set", 8'h01, zero_flag);
  endtask : t_reset
  task automatic t_refuse;
    op(4'hD, 8'h33);
    cmp("bad done", 8'h00, op_done);
    op(4'h0, 8'h33);
    cmp("nop done", 8'h01, op_done);
    clk_en = 1'b0;
    op(4'h4, 8'h33);
    clk_en = 1'b1;
    cmp("frozen acc", 8'h00, acc);
    cmp("frozen done", 8'h01, op_done);
  endtask : t_refuse
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    op_valid = 1'b0;
    op_code = 4'h0;
    mem_rd_data = 8'h00;
    repeat (10) @(posedge core_clk);
    #1;
    rst = 1'b0;
    cmp("reset acc", 8'h00, acc);
    t_rot;
    t_incdec;
    t_move_or;
    t_refuse;
    t_reset;
    end_sim;
  end
  // The tests need about fifty cycles; this leaves a wide margin.
  initial begin
    #40000;
    err_count++;
    end_sim;
  end
endmodule : tb_top
`default_nettype wire

// ### logic/alu_result_calc.sv
`timescale 1ns/100ps
`default_nettype none
`include "mem_alu_defs.svh"

module alu_result_calc (
  input  wire logic [`OP_W-1:0]   op,
  input  wire logic [`DATA_W-1:0] mem_data,
  input  wire logic [`DATA_W-1:0] acc_in,
  input  wire logic               carry_in,
  output logic [`DATA_W-1:0]      result,
  output logic                    to_acc,
  output logic                    to_mem,
  output logic                    sets_zero,
  output logic                    sets_carry,
  output logic                    carry_out,
  output logic                    known
);

  always_comb begin
    result     = mem_data;
    to_acc     = 1'b0;
    to_mem     = 1'b0;
    sets_zero  = 1'b0;
    sets_carry = 1'b0;
    carry_out  = carry_in;
    known      = 1'b1;
    unique case (mem_alu_pkg::alu_op_e'(op))
      mem_alu_pkg::mem_decrement_to_acc: begin
        result    = mem_data - `ONE_BYTE;
        to_acc    = 1'b1;
        sets_zero = 1'b1;
      end
      mem_alu_pkg::mem_increment_in_place: begin
        result    = mem_data + `ONE_BYTE;
        to_mem    = 1'b1;
        sets_zero = 1'b1;
      end
      mem_alu_pkg::mem_increment_to_acc: begin
        result    = mem_data + `ONE_BYTE;
        to_acc    = 1'b1;
        sets_zero = 1'b1;
      end
      mem_alu_pkg::mem_acc_copy_to_acc: begin
        to_acc = 1'b1;
      end
      mem_alu_pkg::mem_acc_copy_to_mem: begin
        result = acc_in;
        to_mem = 1'b1;
      end
      mem_alu_pkg::or_into_acc: begin
        result    = acc_in | mem_data;
        to_acc    = 1'b1;
        sets_zero = 1'b1;
      end
      mem_alu_pkg::or_into_mem: begin
        result    = acc_in | mem_data;
        to_mem    = 1'b1;
        sets_zero = 1'b1;
      end
      mem_alu_pkg::rotate_left_in_place: begin
        result = {mem_data[`MSB_POS-1:`LSB_POS], mem_data[`MSB_POS]};
        to_mem = 1'b1;
      end
      mem_alu_pkg::rotate_left_to_acc: begin
        result = {mem_data[`MSB_POS-1:`LSB_POS], mem_data[`MSB_POS]};
        to_acc = 1'b1;
      end
      mem_alu_pkg::rotate_left_thru_carry_mem: begin
        result     = {mem_data[`MSB_POS-1:`LSB_POS], carry_in};
        to_mem     = 1'b1;
        sets_carry = 1'b1;
        carry_out  = mem_data[`MSB_POS];
      end
      mem_alu_pkg::rotate_left_thru_carry_acc: begin
        result     = {mem_data[`MSB_POS-1:`LSB_POS], carry_in};
        to_acc     = 1'b1;
        sets_carry = 1'b1;
        carry_out  = mem_data[`MSB_POS];
      end
      mem_alu_pkg::rotate_right_in_place: begin
        result = {mem_data[`LSB_POS], mem_data[`MSB_POS:`LSB_POS+1]};
        to_mem = 1'b1;
      end
      mem_alu_pkg::op_none: begin
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

endmodule : alu_result_calc
`default_nettype wire

// ### logic/mem_inc_dec_move_or_rotate_alu.sv
// Contract
// - Decrement: accumulator gets memory minus one, memory kept, zero flag only.
// - Increment in place: memory gets itself plus one, zero flag only.
// - Increment to accumulator: accumulator gets memory plus one, zero flag only.
// - Memory to accumulator copy; no flag changes.
// - Accumulator to memory copy; no flag changes.
// - Accumulator OR memory into accumulator; zero flag only.
// - Accumulator OR memory written back to memory; zero flag only.
// - Memory rotated left in place, bit 7 to bit 0, no flags.
// - Memory rotated left into accumulator, memory kept, no flags.
// - Memory rotated left through carry in place; carry takes old bit 7.
// - Rotate left through carry into accumulator; memory kept; carry takes bit 7.
// - Memory rotated right in place, bit 0 to bit 7, no flags.
`timescale 1ns/100ps
`default_nettype none
`include "mem_alu_defs.svh"

module mem_inc_dec_move_or_rotate_alu #(
  parameter int DATA_W = `DATA_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic              op_valid,
  input  wire logic [`OP_W-1:0]  op_code,
  input  wire logic [DATA_W-1:0] mem_rd_data,
  output logic [DATA_W-1:0]      acc,
  output logic                   zero_flag,
  output logic                   carry_flag,
  output logic [DATA_W-1:0]      mem_wr_data,
  output logic                   mem_wr_en,
  output logic                   op_done
);

  mem_alu_pkg::alu_state_s state_r;
  mem_alu_pkg::alu_state_s state_nxt;

  logic [DATA_W-1:0] result;
  logic              to_acc;
  logic              to_mem;
  logic              sets_zero;
  logic              sets_carry;
  logic              carry_out;
  logic              known;

  alu_result_calc u_calc (
    .op         (op_code),
    .mem_data   (mem_rd_data),
    .acc_in     (state_r.acc),
    .carry_in   (state_r.carry),
    .result     (result),
    .to_acc     (to_acc),
    .to_mem     (to_mem),
    .sets_zero  (sets_zero),
    .sets_carry (sets_carry),
    .carry_out  (carry_out),
    .known      (known)
  );

  // Results land one cycle after the request; memory write is a one-cycle strobe.
  always_comb begin
    state_nxt         = state_r;
    state_nxt.wr_en   = 1'b0;
    state_nxt.done    = 1'b0;
    if (op_valid) begin
      state_nxt.done = known;
      if (to_acc) begin
        state_nxt.acc = result;
      end
      if (to_mem) begin
        state_nxt.wr_data = result;
        state_nxt.wr_en   = 1'b1;
      end
      if (sets_zero) begin
        state_nxt.zero = (result == `ZERO_BYTE);
      end
      if (sets_carry) begin
        state_nxt.carry = carry_out;
      end
    end
  end

  // Clock enable low freezes everything, including a pending write strobe.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= '{acc: `ACC_RESET, zero: `FLAG_RESET, carry: `FLAG_RESET,
                   wr_data: `ZERO_BYTE, wr_en: 1'b0, done: 1'b0};
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  assign acc         = state_r.acc;
  assign zero_flag   = state_r.zero;
  assign carry_flag  = state_r.carry;
  assign mem_wr_data = state_r.wr_data;
  assign mem_wr_en   = state_r.wr_en;
  assign op_done     = state_r.done;

endmodule : mem_inc_dec_move_or_rotate_alu
`default_nettype wire

// ### shared/mem_alu_defs.svh
`ifndef MEM_ALU_DEFS_SVH
`define MEM_ALU_DEFS_SVH

`define DATA_W        8
`define OP_W          4
`define MSB_POS       7
`define LSB_POS       0
`define ONE_BYTE      8'h01
`define ZERO_BYTE     8'h00
`define ACC_RESET     8'h00
`define FLAG_RESET    1'b0
`define OP_NONE       4'h0
`define OP_DEC_ACC    4'h1
`define OP_INC_MEM    4'h2
`define OP_INC_ACC    4'h3
`define OP_MOV_M2A    4'h4
`define OP_MOV_A2M    4'h5
`define OP_OR_ACC     4'h6
`define OP_OR_MEM     4'h7
`define OP_RL_MEM     4'h8
`define OP_RL_ACC     4'h9
`define OP_RLC_MEM    4'hA
`define OP_RLC_ACC    4'hB
`define OP_RR_MEM     4'hC

`endif

// ### shared/mem_alu_pkg.sv
`include "mem_alu_defs.svh"

package mem_alu_pkg;

  typedef enum logic [`OP_W-1:0] {
    op_none                    = `OP_NONE,
    mem_decrement_to_acc       = `OP_DEC_ACC,
    mem_increment_in_place     = `OP_INC_MEM,
    mem_increment_to_acc       = `OP_INC_ACC,
    mem_acc_copy_to_acc        = `OP_MOV_M2A,
    mem_acc_copy_to_mem        = `OP_MOV_A2M,
    or_into_acc                = `OP_OR_ACC,
    or_into_mem                = `OP_OR_MEM,
    rotate_left_in_place       = `OP_RL_MEM,
    rotate_left_to_acc         = `OP_RL_ACC,
    rotate_left_thru_carry_mem = `OP_RLC_MEM,
    rotate_left_thru_carry_acc = `OP_RLC_ACC,
    rotate_right_in_place      = `OP_RR_MEM
  } alu_op_e;

  typedef logic [`DATA_W-1:0] byte_t;

  typedef struct packed {
    byte_t      acc;
    logic       zero;
    logic       carry;
    byte_t      wr_data;
    logic       wr_en;
    logic       done;
  } alu_state_s;

endpackage : mem_alu_pkg
